// ### src/rstc_cfg.svh
`ifndef RSTC_CFG_SVH
`define RSTC_CFG_SVH

// Register byte offsets
`define RSTC_OFF_COMMAND 8'h00
`define RSTC_OFF_STATUS 8'h04
`define RSTC_OFF_MODE 8'h08
`define RSTC_OFF_IRQ_STATUS 8'h0c
`define RSTC_OFF_IRQ_MASK 8'h10

// Password field
`define RSTC_KEY 8'ha5
`define RSTC_KEY_MSB 31
`define RSTC_KEY_LSB 24

// Command bits
`define RSTC_CMD_CPU_BIT 0
`define RSTC_CMD_PERIPH_BIT 2
`define RSTC_CMD_PIN_BIT 3

// Status fields
`define RSTC_ST_FLAG_BIT 0
`define RSTC_ST_CAUSE_LSB 8
`define RSTC_ST_LEVEL_BIT 16
`define RSTC_ST_BUSY_BIT 17

// Mode fields and reset value
`define RSTC_MODE_USER_EN_BIT 0
`define RSTC_MODE_IRQ_EN_BIT 4
`define RSTC_MODE_LEN_LSB 8
`define RSTC_MODE_RESET 6'h00

// Cause codes
`define RSTC_CAUSE_GENERAL 3'h0
`define RSTC_CAUSE_WAKE 3'h1
`define RSTC_CAUSE_WDT 3'h2
`define RSTC_CAUSE_SW 3'h3
`define RSTC_CAUSE_USER 3'h4

// Slow-clock lengths of reset phases
`define RSTC_PHASE_TICKS 2'h3

// Event interrupt bits
`define RSTC_IRQ_EDGE_BIT 0
`define RSTC_IRQ_DONE_BIT 1

`endif

// ### src/rstc_pin_pulse.sv
`timescale 1ns/1ps
module rstc_pin_pulse #(
  parameter int CNT_W = 17,
  parameter int LEN_W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic [LEN_W-1:0] len,
  input wire logic tick,
  // Pin drive request
  output logic busy
);

  logic busy_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] target_reg;

  // Counts 2^(len+1) slow ticks, length latched at start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      target_reg <= '0;
    end else if (start) begin
      busy_reg <= 1'b1;
      cnt_reg <= '0;
      target_reg <= {{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, len} + 5'h01);
    end else if (busy_reg && tick) begin
      if (cnt_reg == target_reg - {{(CNT_W-1){1'b0}}, 1'b1}) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy = busy_reg;

endmodule : rstc_pin_pulse

// ### src/rstc_pkg.sv
package rstc_pkg;

  // Reset sequencer states
  typedef enum logic [2:0] {
    RSTC_IDLE,
    RSTC_SW,
    RSTC_WDT,
    RSTC_USER,
    RSTC_USER_WAIT
  } rstc_state_type;

  // Mode register contents
  typedef struct packed {
    logic [3:0] pulse_len;
    logic irq_en;
    logic user_en;
  } rstc_mode_type;

  // Latched software command
  typedef struct packed {
    logic cpu;
    logic periph;
    logic pin;
  } rstc_cmd_type;

endpackage : rstc_pkg

// ### src/rstc_regs.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "rstc_cfg.svh"
// Notes on behaviour
// - Keyed command bit 0 resets processor
// - Keyed command bit 2 resets peripherals
// - Keyed command bit 3 drives pin low
// - Command and mode writes need key a5
// - Status bit 0 flags pin falling edge
// - Status bits 10:8 hold reset cause
// - Status read keeps cause unchanged
// - Status bit 16 shows synced pin level
// - Status bit 17 shows software reset busy
// - Mode bit 0 enables pin user reset
// - Mode bit 4 routes edge flag to irq when mode bit 0 is clear
// - Mode bits 11:8 set pin pulse length
// - Reset cause general or wake after reset
// - Software reset lasts three slow cycles
// - Command writes ignored while busy
// - Status read clears edge flag and the irq it raises, not the event status bits
// - Cause records software only with cpu bit
module rstc_regs import rstc_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int PULSE_CNT_W = 17
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Slow clock and reset pin
  input wire logic slow_clk_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // System inputs
  input wire logic wdt_fault,
  input wire logic wake_strap,
  // Reset and interrupt outputs
  output logic cpu_reset,
  output logic periph_reset,
  output logic irq
);

  // Address match on the low byte, upper bits must be zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    reg_hit = (addr == ADDR_W'(off));
  endfunction : reg_hit

  rstc_state_type state_reg, state_next;
  rstc_mode_type mode_reg;
  rstc_cmd_type cmd_reg;
  logic [1:0] tick_cnt_reg;
  logic [2:0] cause_reg;
  logic cause_loaded_reg;
  logic pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic [2:0] drive_hist_reg;
  logic pin_edge_flag;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic slow_tick, pulse_busy, pulse_start;
  logic access, wr, rd, key_ok, mapped;
  logic cmd_wr, sw_req, mode_wr, st_rd, sw_busy;
  logic pin_fall, pin_guard, user_req, phase_end, sw_done;
  logic [31:0] rd_value;

  // Slow clock edge detector
  rstc_slow_tick u_tick (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .slow_clk_in(slow_clk_in),
    .tick(slow_tick)
  );

  // External pin pulse timer
  rstc_pin_pulse #(
    .CNT_W(PULSE_CNT_W),
    .LEN_W(4)
  ) u_pulse (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(pulse_start),
    .len(mode_reg.pulse_len),
    .tick(slow_tick),
    .busy(pulse_busy)
  );

  // APB decode
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign key_ok = (pwdata[`RSTC_KEY_MSB:`RSTC_KEY_LSB] == `RSTC_KEY);
  assign mapped = reg_hit(paddr, `RSTC_OFF_COMMAND) | reg_hit(paddr, `RSTC_OFF_STATUS) |
                  reg_hit(paddr, `RSTC_OFF_MODE) | reg_hit(paddr, `RSTC_OFF_IRQ_STATUS) |
                  reg_hit(paddr, `RSTC_OFF_IRQ_MASK);
  assign sw_busy = (state_reg == RSTC_SW);
  assign cmd_wr = wr & reg_hit(paddr, `RSTC_OFF_COMMAND) & key_ok & (state_reg == RSTC_IDLE);
  assign sw_req = cmd_wr & (pwdata[`RSTC_CMD_CPU_BIT] | pwdata[`RSTC_CMD_PERIPH_BIT] |
                            pwdata[`RSTC_CMD_PIN_BIT]);
  assign mode_wr = wr & reg_hit(paddr, `RSTC_OFF_MODE) & key_ok;
  assign st_rd = rd & reg_hit(paddr, `RSTC_OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_reg;

  // Pin synchroniser and falling edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      drive_hist_reg <= 3'h0;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      drive_hist_reg <= {drive_hist_reg[1:0], pulse_busy};
    end
  end

  assign pin_fall = pin_prev_reg & ~pin_s2_reg;
  // Own drive and its echo through the synchroniser never start a user reset
  assign pin_guard = pulse_busy | (|drive_hist_reg);
  assign user_req = mode_reg.user_en & ~pin_s2_reg & ~pin_guard;
  assign phase_end = slow_tick & (tick_cnt_reg == `RSTC_PHASE_TICKS - 2'h1);

  // Sequencer, watchdog over software over user
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSTC_IDLE: begin
        if (wdt_fault) begin
          state_next = RSTC_WDT;
        end else if (sw_req) begin
          state_next = RSTC_SW;
        end else if (user_req) begin
          state_next = RSTC_USER;
        end
      end
      RSTC_SW: begin
        if (wdt_fault) begin
          state_next = RSTC_WDT;
        end else if (phase_end) begin
          state_next = RSTC_IDLE;
        end
      end
      RSTC_WDT: begin
        if (phase_end) begin
          state_next = RSTC_IDLE;
        end
      end
      RSTC_USER: begin
        if (pin_s2_reg) begin
          state_next = RSTC_USER_WAIT;
        end
      end
      RSTC_USER_WAIT: begin
        if (!pin_s2_reg) begin
          state_next = RSTC_USER;
        end else if (phase_end) begin
          state_next = RSTC_IDLE;
        end
      end
      default: state_next = RSTC_IDLE;
    endcase
  end

  // State and slow tick counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RSTC_IDLE;
      tick_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        tick_cnt_reg <= 2'h0;
      end else if (slow_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 2'h1;
      end
    end
  end

  // Latched software command
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= '0;
    end else if (sw_req && !wdt_fault) begin
      cmd_reg.cpu <= pwdata[`RSTC_CMD_CPU_BIT];
      cmd_reg.periph <= pwdata[`RSTC_CMD_PERIPH_BIT];
      cmd_reg.pin <= pwdata[`RSTC_CMD_PIN_BIT];
    end
  end

  // Reset outputs from state and latched command
  assign cpu_reset = (sw_busy & cmd_reg.cpu) | (state_reg == RSTC_WDT) |
                     (state_reg == RSTC_USER) | (state_reg == RSTC_USER_WAIT);
  assign periph_reset = (sw_busy & cmd_reg.periph) | (state_reg == RSTC_WDT) |
                        (state_reg == RSTC_USER) | (state_reg == RSTC_USER_WAIT);
  // Pin pulse on keyed command or watchdog entry
  assign pulse_start = (state_reg != RSTC_WDT && state_next == RSTC_WDT) |
                       (sw_req & ~wdt_fault & pwdata[`RSTC_CMD_PIN_BIT]);
  assign pin_out = 1'b0;
  assign pin_oe = pulse_busy;

  // Cause field: strap after release, updated as the processor reset ends
  assign sw_done = sw_busy & (state_next == RSTC_IDLE);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_reg <= `RSTC_CAUSE_GENERAL;
      cause_loaded_reg <= 1'b0;
    end else begin
      cause_loaded_reg <= 1'b1;
      if (!cause_loaded_reg) begin
        cause_reg <= wake_strap ? `RSTC_CAUSE_WAKE : `RSTC_CAUSE_GENERAL;
      end else if (state_reg != RSTC_IDLE && state_next == RSTC_IDLE) begin
        case (state_reg)
          RSTC_SW: cause_reg <= cmd_reg.cpu ? `RSTC_CAUSE_SW : cause_reg;
          RSTC_WDT: cause_reg <= `RSTC_CAUSE_WDT;
          RSTC_USER_WAIT: cause_reg <= `RSTC_CAUSE_USER;
          default: cause_reg <= cause_reg;
        endcase
      end
    end
  end

  // Mode register, keyed writes only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= `RSTC_MODE_RESET;
    end else if (mode_wr) begin
      mode_reg.pulse_len <= pwdata[`RSTC_MODE_LEN_LSB +: 4];
      mode_reg.irq_en <= pwdata[`RSTC_MODE_IRQ_EN_BIT];
      mode_reg.user_en <= pwdata[`RSTC_MODE_USER_EN_BIT];
    end
  end

  // Edge flag: a new edge wins over the clear of the read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_edge_flag <= 1'b0;
    end else begin
      pin_edge_flag <= pin_fall | (pin_edge_flag & ~(st_rd & prdata_reg[`RSTC_ST_FLAG_BIT]));
    end
  end

  // Event status (write one to clear) and mask
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      if (wr && reg_hit(paddr, `RSTC_OFF_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[1:0];
      end
      irq_status_reg[`RSTC_IRQ_EDGE_BIT] <= pin_fall | (irq_status_reg[`RSTC_IRQ_EDGE_BIT] &
        ~(wr & reg_hit(paddr, `RSTC_OFF_IRQ_STATUS) & pwdata[`RSTC_IRQ_EDGE_BIT]));
      irq_status_reg[`RSTC_IRQ_DONE_BIT] <= sw_done | (irq_status_reg[`RSTC_IRQ_DONE_BIT] &
        ~(wr & reg_hit(paddr, `RSTC_OFF_IRQ_STATUS) & pwdata[`RSTC_IRQ_DONE_BIT]));
    end
  end

  assign irq = (|(irq_status_reg & irq_mask_reg)) |
               (pin_edge_flag & mode_reg.irq_en & ~mode_reg.user_en);

  // Read mux, captured in the setup phase
  always_comb begin
    rd_value = 32'h0000_0000;
    if (reg_hit(paddr, `RSTC_OFF_STATUS)) begin
      rd_value[`RSTC_ST_FLAG_BIT] = pin_edge_flag;
      rd_value[`RSTC_ST_CAUSE_LSB +: 3] = cause_reg;
      rd_value[`RSTC_ST_LEVEL_BIT] = pin_s2_reg;
      rd_value[`RSTC_ST_BUSY_BIT] = sw_busy;
    end else if (reg_hit(paddr, `RSTC_OFF_MODE)) begin
      rd_value[`RSTC_MODE_USER_EN_BIT] = mode_reg.user_en;
      rd_value[`RSTC_MODE_IRQ_EN_BIT] = mode_reg.irq_en;
      rd_value[`RSTC_MODE_LEN_LSB +: 4] = mode_reg.pulse_len;
    end else if (reg_hit(paddr, `RSTC_OFF_IRQ_STATUS)) begin
      rd_value[1:0] = irq_status_reg;
    end else if (reg_hit(paddr, `RSTC_OFF_IRQ_MASK)) begin
      rd_value[1:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_value;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence sw_accept_s;
    sw_req && !wdt_fault;
  endsequence

  sequence sw_run_s;
    sw_busy [*1];
  endsequence

  cpu_cmd_a: assert property (sw_accept_s ##0 pwdata[0] |=> sw_run_s ##0 cpu_reset)
    else $error("cpu reset not raised by keyed command");

  periph_cmd_a: assert property (sw_accept_s ##0 pwdata[2] |=> periph_reset && !(cmd_reg.cpu ^ $past(pwdata[0])))
    else $error("peripheral reset not raised by keyed command");

  pin_cmd_a: assert property (sw_accept_s ##0 pwdata[3] |-> ##[1:2] pin_oe)
    else $error("pin not driven after keyed command");

  key_gate_a: assert property (wr && !key_ok |=> $stable(mode_reg) && state_reg != RSTC_SW || $past(sw_busy))
    else $error("write with bad key took effect");

  edge_flag_a: assert property (pin_fall |=> pin_edge_flag)
    else $error("pin falling edge not flagged");

  cause_read_a: assert property (st_rd && state_reg == RSTC_IDLE && cause_loaded_reg |=> $stable(cause_reg))
    else $error("status read changed reset cause");

  busy_flag_a: assert property (sw_accept_s |=> sw_busy)
    else $error("busy not shown after command");

  ignore_busy_a: assert property (sw_busy && wr && reg_hit(paddr, 8'h00) |=> $stable(cmd_reg))
    else $error("command accepted while busy");

  user_off_a: assert property (state_reg == RSTC_IDLE && !mode_reg.user_en && !wdt_fault && !sw_req
    |=> state_reg != RSTC_USER)
    else $error("user reset while disabled");

  irq_route_a: assert property (pin_edge_flag && mode_reg.irq_en && !mode_reg.user_en |-> irq)
    else $error("edge interrupt missing");

  read_clear_a: assert property (st_rd && prdata_reg[0] && !pin_fall |=> !pin_edge_flag)
    else $error("status read did not clear edge flag");

  sw_len_a: assert property (sw_busy && state_next == RSTC_IDLE |-> tick_cnt_reg == 2'h2 && slow_tick)
    else $error("software reset length wrong");

  sw_cause_a: assert property (sw_done && !cmd_reg.cpu |=> $stable(cause_reg))
    else $error("cause updated without cpu command");

  reserved_a: assert property (st_rd |-> prdata[31:18] == 14'h0000 && prdata[15:11] == 5'h00)
    else $error("reserved status bits not zero");

endmodule : rstc_regs

// ### src/rstc_slow_tick.sv
`timescale 1ns/1ps
module rstc_slow_tick (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Slow clock pin
  input wire logic slow_clk_in,
  // One master-clock pulse per slow rising edge
  output logic tick
);

  logic s1_reg, s2_reg, s3_reg, tick_reg;

  // Two-stage synchroniser, then rising-edge detect
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      s1_reg <= slow_clk_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      tick_reg <= s2_reg & ~s3_reg;
    end
  end

  assign tick = tick_reg;

endmodule : rstc_slow_tick

// ### tb/rstc_board.sv
`timescale 1ns/1ps
module rstc_board (
  // Drive from the block
  input wire logic pin_out,
  input wire logic pin_oe,
  // Board pushbutton or supervisor pulling low
  input wire logic ext_low,
  // Resolved pin level
  output logic pin_line
);
  // Open-drain line with pull-up: low when the block or the board pulls it
  assign pin_line = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule : rstc_board

// ### tb/tb_reset_controller_regs.sv
`timescale 1ns/1ps
module tb_reset_controller_regs;
  // Stimulus and observed signals
  logic core_clk = 1'b0, arst_n = 1'b0, slow_clk = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wdt_fault = 1'b0, wake_strap = 1'b1, ext_low = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic err, pready, pslverr, pin_line, pin_out, pin_oe, cpu_reset, periph_reset, irq;
  int err_count = 0, checked = 0, cpu_cnt = 0, oe_cnt = 0;

  rstc_regs rstc_regs_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clk_in(slow_clk), .pin_in(pin_line), .pin_out(pin_out),
    .pin_oe(pin_oe), .wdt_fault(wdt_fault), .wake_strap(wake_strap), .cpu_reset(cpu_reset),
    .periph_reset(periph_reset), .irq(irq));
  rstc_board rstc_board_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low), .pin_line(pin_line));

  // Clocks: 40 MHz core, unrelated slow clock of 16 core periods
  always #12.5 core_clk = ~core_clk;
  always #200 slow_clk = ~slow_clk;
  // Length counters for reset and pin pulses
  always @(posedge core_clk) begin
    if (cpu_reset === 1'b1) cpu_cnt++;
    if (pin_oe === 1'b1) oe_cnt++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask : idle

  task wait_low(input int which);
    int k;
    k = 0;
    while (k < 400 && (which == 0 ? cpu_reset : which == 1 ? periph_reset : pin_oe) !== 1'b0) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 400) err_count++;
    idle(4);
  endtask : wait_low

  task t_reset;
    apb(0, 8'h04, 0); chk(rd, 32'h0001_0100);
    apb(1, 8'h04, 32'ha5ff_ffff); apb(0, 8'h04, 0); chk(rd, 32'h0001_0100);
    apb(1, 8'h08, 32'ha5ff_ffff); apb(0, 8'h08, 0); chk(rd, 32'h0000_0f11);
    apb(1, 8'h08, 32'ha500_0000); apb(0, 8'h1c, 0); chk({31'h0, err}, 1);
  endtask : t_reset

  task t_key;
    apb(1, 8'h00, 32'h5a00_000d); idle(4);
    chk({cpu_reset, periph_reset, pin_oe}, 0);
    apb(1, 8'h08, 32'h5a00_0011); apb(0, 8'h08, 0); chk(rd, 0);
  endtask : t_key

  task t_sw;
    apb(1, 8'h00, 32'ha500_0004); idle(2);
    chk({cpu_reset, periph_reset}, 2'b01);
    apb(1, 8'h00, 32'ha500_0001); apb(0, 8'h04, 0); chk(rd[17], 1);
    chk(cpu_reset, 0);
    wait_low(1); apb(0, 8'h04, 0); chk(rd[17], 0);
    chk(rd[10:8], 3'h1);
    apb(1, 8'h00, 32'ha500_0000); idle(2); chk({cpu_reset, periph_reset}, 0);
    cpu_cnt = 0;
    apb(1, 8'h00, 32'ha500_0001); idle(2); chk(cpu_reset, 1);
    wait_low(0); chk(cpu_cnt >= 32 && cpu_cnt <= 56, 1);
    apb(0, 8'h04, 0); chk(rd[10:8], 3'h3);
  endtask : t_sw

  task t_pin(input logic [3:0] len, input int lo, input int hi);
    apb(1, 8'h08, {8'ha5, 12'h0, len, 8'h00}); apb(0, 8'h04, 0);
    oe_cnt = 0;
    apb(1, 8'h00, 32'ha500_0008); idle(2); chk(pin_oe, 1);
    wait_low(2); chk(oe_cnt >= lo && oe_cnt <= hi, 1);
    idle(64); apb(0, 8'h04, 0); chk({rd[16], rd[0]}, 2'b11);
    chk(rd[10:8], 3'h3);
    apb(0, 8'h04, 0); chk(rd[0], 0);
  endtask : t_pin

  task t_irq;
    apb(1, 8'h0c, 32'h3); apb(0, 8'h0c, 0); chk(rd, 0);
    apb(1, 8'h08, 32'ha500_0010); apb(0, 8'h04, 0);
    ext_low <= 1'b1; idle(8);
    chk({irq, cpu_reset}, 2'b10);
    apb(0, 8'h04, 0); chk({rd[16], rd[0]}, 2'b01);
    ext_low <= 1'b0; idle(2); chk(irq, 0);
    apb(1, 8'h08, 32'ha500_0000); apb(1, 8'h10, 32'h1); idle(2); chk(irq, 1);
    apb(1, 8'h10, 32'h0); idle(2); chk(irq, 0);
    apb(1, 8'h10, 32'h1); apb(1, 8'h0c, 32'h1); idle(2); chk(irq, 0);
    apb(1, 8'h10, 32'h0);
    apb(1, 8'h08, 32'ha500_0011); apb(0, 8'h04, 0);
    ext_low <= 1'b1; idle(8);
    chk({cpu_reset, irq}, 2'b10);
    ext_low <= 1'b0; wait_low(0);
    apb(0, 8'h04, 0); chk(rd[10:8], 3'h4);
    apb(1, 8'h08, 32'ha500_0000);
  endtask : t_irq

  task t_wdt;
    wdt_fault <= 1'b1; idle(1); wdt_fault <= 1'b0; idle(2);
    chk({cpu_reset, periph_reset}, 2'b11);
    wait_low(0); idle(64); apb(0, 8'h04, 0); chk(rd[10:8], 3'h2);
  endtask : t_wdt

  // Second reset in mid-run, strap low: general cause, mode cleared
  task t_rerst;
    wake_strap <= 1'b0; arst_n <= 1'b0; idle(3);
    chk({cpu_reset, periph_reset, pin_oe, irq}, 0);
    arst_n <= 1'b1; idle(2);
    apb(0, 8'h04, 0); chk(rd, 32'h0001_0000);
    apb(0, 8'h08, 0); chk(rd, 0);
  endtask : t_rerst

  task test_done;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    idle(3);
    arst_n <= 1'b1;
    idle(2);
    t_reset;
    t_key;
    t_sw;
    t_pin(4'h0, 16, 40);
    t_pin(4'h2, 112, 136);
    t_irq;
    t_wdt;
    t_rerst;
    test_done;
  end

  // Hang guard
  initial begin
    #400us;
    err_count++;
    test_done;
  end
endmodule : tb_reset_controller_regs
